// File: include/line_cfg_if.sv
`timescale 1ns/1ps
interface line_cfg_if;
    import lio_pkg::*;
    func_t code;
    logic pin_level;
    logic no_fault;
    logic ready;
    logic gp_level;
    logic out_level;
    logic is_out;
    in_roles_s roles;

    modport ctrl (
        output code, pin_level, no_fault, ready, gp_level,
        input out_level, is_out, roles
    );
    modport dec (
        input code, pin_level, no_fault, ready, gp_level,
        output out_level, is_out, roles
    );
endinterface

// File: include/lio_map.svh
`ifndef LIO_MAP_SVH
`define LIO_MAP_SVH

// parameter addresses of the line function selectors
`define SEL1_ADDR 16'h0722
`define SEL2_ADDR 16'h0724
`define SEL3_ADDR 16'h0726
`define SEL4_ADDR 16'h0728
// input level readback and output level parameters
`define IN_LEVELS_ADDR 16'h0730
`define OUT_LEVELS_ADDR 16'h0732

// function selector codes
`define FN_FREE_IN 16'h0001
`define FN_FAULT_RST 16'h0002
`define FN_ENABLE 16'h0003
`define FN_HALT 16'h0004
`define FN_JOG_POS 16'h0009
`define FN_JOG_NEG 16'h000a
`define FN_JOG_FAST 16'h000b
`define FN_HOME_REF 16'h0014
`define FN_POS_LIM 16'h0015
`define FN_NEG_LIM 16'h0016
`define FN_FREE_OUT 16'h0065
`define FN_NO_FAULT 16'h0066
`define FN_READY 16'h0067

// factory assignment of the four lines
`define LINE1_FACTORY `FN_POS_LIM
`define LINE2_FACTORY `FN_NEG_LIM
`define LINE3_FACTORY `FN_FREE_IN
`define LINE4_FACTORY `FN_HOME_REF
`define OUT_LEVELS_RESET 4'h0

`endif

// File: include/lio_pkg.sv
package lio_pkg;
`include "lio_map.svh"

typedef logic [15:0] func_t;

typedef enum logic [2:0] {
    st_start,
    st_not_ready,
    st_switch_on_disabled,
    st_ready_to_switch_on,
    st_switched_on,
    st_operation_enabled,
    st_fault
} op_state_e;

typedef struct packed {
    logic free_in;
    logic fault_rst;
    logic enable;
    logic halt;
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
    logic home_ref;
    logic pos_lim;
    logic neg_lim;
} in_roles_s;

// codes that a given line accepts
function automatic logic func_valid(input logic [1:0] idx, input func_t code);
    logic ok;
    ok = 1'b0;
    case (code)
        `FN_FREE_IN, `FN_FAULT_RST, `FN_ENABLE, `FN_HALT,
        `FN_JOG_POS, `FN_JOG_NEG, `FN_JOG_FAST, `FN_HOME_REF,
        `FN_FREE_OUT, `FN_NO_FAULT, `FN_READY: ok = 1'b1;
        `FN_POS_LIM: ok = (idx == 2'd0);
        `FN_NEG_LIM: ok = (idx == 2'd1);
        default: ok = 1'b0;
    endcase
    return ok;
endfunction

endpackage

// File: src/line_func_decode.sv
`timescale 1ns/1ps
`include "lio_map.svh"
module line_func_decode (
    line_cfg_if.dec lc
);
    import lio_pkg::*;

    always_comb begin
        lc.roles = '0;
        lc.out_level = 1'b0;
        lc.is_out = 1'b0;
        case (lc.code)
            `FN_FREE_IN: lc.roles.free_in = lc.pin_level; // R1
            `FN_FAULT_RST: lc.roles.fault_rst = lc.pin_level; // R2
            `FN_ENABLE: lc.roles.enable = lc.pin_level; // R3
            `FN_HALT: lc.roles.halt = lc.pin_level; // R4
            `FN_JOG_POS: lc.roles.jog_pos = lc.pin_level; // R5
            `FN_JOG_NEG: lc.roles.jog_neg = lc.pin_level; // R5
            `FN_JOG_FAST: lc.roles.jog_fast = lc.pin_level; // R5
            `FN_HOME_REF: lc.roles.home_ref = lc.pin_level; // R6
            `FN_POS_LIM: lc.roles.pos_lim = lc.pin_level; // R7
            `FN_NEG_LIM: lc.roles.neg_lim = lc.pin_level; // R8
            `FN_FREE_OUT: begin
                lc.is_out = 1'b1;
                lc.out_level = lc.gp_level; // R9
            end
            `FN_NO_FAULT: begin
                lc.is_out = 1'b1;
                lc.out_level = lc.no_fault; // R10
            end
            `FN_READY: begin
                lc.is_out = 1'b1;
                lc.out_level = lc.ready; // R11
            end
            default: begin
                lc.is_out = 1'b0;
            end
        endcase
    end
endmodule

// File: src/multi_io_function_select.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - code 1 makes the line a plain input readable by software
// R2 - code 2 is a fault reset input, honoured in local control only
// R3 - code 3 is an enable input, honoured in local control only
// R4 - code 4 is a halt input requesting the movement to stop
// R5 - codes 9, 10, 11 are jog positive, jog negative, jog fast/slow inputs
// R6 - code 20 is the homing reference switch, allowed on all lines
// R7 - code 21, positive limit switch, allowed on line 1 only
// R8 - code 22, negative limit switch, allowed on line 2 only
// R9 - code 101 is a general output driven from a writable parameter
// R10 - code 102 is an output asserted while no fault is present
// R11 - code 103 is an output showing the drive enabled and ready
// R12 - selector writes take effect only while the power stage is off
// R13 - a new selection is stored, used only after the next power-on
// R14 - power-on and mode start walk the drive through its operating states
// R15 - factory: line1 pos limit, line2 neg limit, line3 input, line4 reference
// R16 - input line levels readable through a dedicated parameter
// R17 - a code not allowed on that line is rejected, old value kept
`include "lio_map.svh"
module multi_io_function_select (
    input wire logic mclk,
    input wire logic srst,
    input wire logic par_req,
    input wire logic par_we,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic par_ack,
    output logic par_err,
    output logic [15:0] par_rdata,
    input wire logic power_up,
    input wire logic elec_init_done,
    input wire logic param_init_done,
    input wire logic supply_ok,
    input wire logic local_mode,
    input wire logic fault_detected,
    input wire logic fb_enable_op,
    input wire logic fb_disable_op,
    input wire logic fb_fault_reset,
    input wire logic mode_start,
    input wire logic multi_line_1_in,
    output logic multi_line_1_out,
    output logic multi_line_1_oe_n,
    input wire logic multi_line_2_in,
    output logic multi_line_2_out,
    output logic multi_line_2_oe_n,
    input wire logic multi_line_3_in,
    output logic multi_line_3_out,
    output logic multi_line_3_oe_n,
    input wire logic multi_line_4_in,
    output logic multi_line_4_out,
    output logic multi_line_4_oe_n,
    output lio_pkg::op_state_e op_state,
    output logic power_stage_on,
    output logic halt_request,
    output logic jog_pos_req,
    output logic jog_neg_req,
    output logic jog_fast_sel,
    output logic home_ref_switch,
    output logic positive_travel_switch,
    output logic negative_travel_switch
);
    import lio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage

    func_t sel_store_r [4];
    func_t sel_act_r [4];
    logic [3:0] gp_out_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] line_out_r;
    logic [3:0] line_oe_n_r;
    op_state_e state_r;
    logic par_ack_r;
    logic par_err_r;
    logic [15:0] par_rdata_r;
    in_roles_s roles_r;

    logic [3:0] pin_in;
    logic [3:0] out_lvl;
    logic [3:0] is_out;
    in_roles_s roles_a [4];
    in_roles_s roles_or;
    logic [3:0] in_levels;
    logic no_fault;
    logic ready;
    logic en_req;
    logic dis_req;
    logic rst_req;
    logic wr;
    logic sel_hit;
    logic [1:0] sel_idx;
    logic wr_ok;
    logic map_hit;

    assign pin_in = {multi_line_4_in, multi_line_3_in, multi_line_2_in, multi_line_1_in};

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per line function decode

    for (genvar i = 0; i < 4; i++) begin : g_line
        line_cfg_if lc ();
        assign lc.code = sel_act_r[i];
        assign lc.pin_level = sync2_r[i];
        assign lc.no_fault = no_fault;
        assign lc.ready = ready;
        assign lc.gp_level = gp_out_r[i];
        assign out_lvl[i] = lc.out_level;
        assign is_out[i] = lc.is_out;
        assign roles_a[i] = lc.roles;
        line_func_decode u_dec (
            .lc(lc)
        );
    end

    // a role is active when any line assigned to it is high
    assign roles_or = roles_a[0] | roles_a[1] | roles_a[2] | roles_a[3];
    assign in_levels = sync2_r & ~is_out; // R16

    always_ff @(posedge mclk) begin
        if (srst) begin
            line_out_r <= 4'h0;
            line_oe_n_r <= 4'hf;
        end else begin
            line_out_r <= out_lvl & is_out;
            line_oe_n_r <= ~is_out;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            roles_r <= '0;
        end else begin
            roles_r <= roles_or;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operating state sequence

    assign no_fault = !fault_detected && (state_r != st_fault);
    assign ready = (state_r == st_operation_enabled);
    assign power_stage_on = (state_r == st_switched_on) || ready;
    assign en_req = fb_enable_op || mode_start || (local_mode && roles_r.enable); // R3
    assign dis_req = fb_disable_op;
    assign rst_req = fb_fault_reset || (local_mode && roles_r.fault_rst); // R2

    always_ff @(posedge mclk) begin
        if (srst || power_up) begin
            state_r <= st_start; // R14
        end else begin
            case (state_r)
                st_start: begin
                    if (elec_init_done) begin
                        state_r <= st_not_ready; // R14
                    end
                end
                st_not_ready: begin
                    if (param_init_done) begin
                        state_r <= st_switch_on_disabled; // R14
                    end
                end
                st_switch_on_disabled: begin
                    if (supply_ok && !fault_detected) begin
                        state_r <= st_ready_to_switch_on;
                    end
                end
                st_ready_to_switch_on: begin
                    if (fault_detected) begin
                        state_r <= st_fault;
                    end else if (en_req) begin
                        state_r <= st_switched_on; // R14
                    end
                end
                st_switched_on: begin
                    if (fault_detected) begin
                        state_r <= st_fault;
                    end else begin
                        state_r <= st_operation_enabled;
                    end
                end
                st_operation_enabled: begin
                    if (fault_detected) begin
                        state_r <= st_fault;
                    end else if (dis_req) begin
                        state_r <= st_ready_to_switch_on;
                    end
                end
                st_fault: begin
                    if (rst_req && !fault_detected) begin
                        state_r <= st_switch_on_disabled; // R2
                    end
                end
                default: begin
                    state_r <= st_start;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter access

    assign wr = par_req && par_we;
    always_comb begin
        sel_hit = 1'b1;
        sel_idx = 2'd0;
        if (par_addr == `SEL1_ADDR) begin
            sel_idx = 2'd0;
        end else if (par_addr == `SEL2_ADDR) begin
            sel_idx = 2'd1;
        end else if (par_addr == `SEL3_ADDR) begin
            sel_idx = 2'd2;
        end else if (par_addr == `SEL4_ADDR) begin
            sel_idx = 2'd3;
        end else begin
            sel_hit = 1'b0;
        end
    end
    assign map_hit = sel_hit || (par_addr == `IN_LEVELS_ADDR)
        || (par_addr == `OUT_LEVELS_ADDR);
    // selector writes need the stage off and a code legal on that line
    assign wr_ok = wr && sel_hit && !power_stage_on // R12
        && func_valid(sel_idx, par_wdata); // R17

    always_ff @(posedge mclk) begin
        if (srst) begin
            sel_store_r[0] <= `LINE1_FACTORY; // R15
            sel_store_r[1] <= `LINE2_FACTORY; // R15
            sel_store_r[2] <= `LINE3_FACTORY; // R15
            sel_store_r[3] <= `LINE4_FACTORY; // R15
        end else if (wr_ok) begin
            sel_store_r[sel_idx] <= par_wdata; // R12
        end
    end

    // active selection follows the stored one only on power-on
    always_ff @(posedge mclk) begin
        if (srst) begin
            sel_act_r[0] <= `LINE1_FACTORY;
            sel_act_r[1] <= `LINE2_FACTORY;
            sel_act_r[2] <= `LINE3_FACTORY;
            sel_act_r[3] <= `LINE4_FACTORY;
        end else if (power_up) begin
            sel_act_r <= sel_store_r; // R13
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            gp_out_r <= `OUT_LEVELS_RESET;
        end else if (wr && par_addr == `OUT_LEVELS_ADDR) begin
            gp_out_r <= par_wdata[3:0]; // R9
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            par_ack_r <= 1'b0;
            par_err_r <= 1'b0;
            par_rdata_r <= 16'h0000;
        end else begin
            par_ack_r <= par_req;
            par_err_r <= par_req && (!map_hit || (wr && sel_hit && !wr_ok)); // R17
            if (par_req && !par_we) begin
                if (sel_hit) begin
                    par_rdata_r <= sel_store_r[sel_idx];
                end else if (par_addr == `IN_LEVELS_ADDR) begin
                    par_rdata_r <= {12'h000, in_levels}; // R16
                end else if (par_addr == `OUT_LEVELS_ADDR) begin
                    par_rdata_r <= {12'h000, gp_out_r};
                end else begin
                    par_rdata_r <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign par_ack = par_ack_r;
    assign par_err = par_err_r;
    assign par_rdata = par_rdata_r;
    assign op_state = state_r;
    assign multi_line_1_out = line_out_r[0];
    assign multi_line_2_out = line_out_r[1];
    assign multi_line_3_out = line_out_r[2];
    assign multi_line_4_out = line_out_r[3];
    assign multi_line_1_oe_n = line_oe_n_r[0];
    assign multi_line_2_oe_n = line_oe_n_r[1];
    assign multi_line_3_oe_n = line_oe_n_r[2];
    assign multi_line_4_oe_n = line_oe_n_r[3];
    assign halt_request = roles_r.halt; // R4
    assign jog_pos_req = roles_r.jog_pos; // R5
    assign jog_neg_req = roles_r.jog_neg; // R5
    assign jog_fast_sel = roles_r.jog_fast; // R5
    assign home_ref_switch = roles_r.home_ref; // R6
    assign positive_travel_switch = roles_r.pos_lim; // R7
    assign negative_travel_switch = roles_r.neg_lim; // R8

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_sel_lock;
        wr && par_addr == `SEL3_ADDR && power_stage_on |=> $stable(sel_store_r[2]) && par_err;
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("selector changed while powered"); // R12

    property p_bad_code;
        wr && par_addr == `SEL4_ADDR && par_wdata == `FN_POS_LIM
            |=> $stable(sel_store_r[3]) && par_err;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("illegal code accepted"); // R17

    property p_no_live;
        !power_up |=> $stable(sel_act_r[2]);
    endproperty
    a_no_live: assert property (p_no_live) else $error("selection changed without power-on"); // R13

    property p_load;
        power_up |=> sel_act_r[2] == $past(sel_store_r[2]);
    endproperty
    a_load: assert property (p_load) else $error("power-on did not load selection"); // R13

    property p_ready_out;
        sel_act_r[2] == `FN_READY && ready |=> multi_line_3_out && !multi_line_3_oe_n;
    endproperty
    a_ready_out: assert property (p_ready_out) else $error("ready output wrong"); // R11

    property p_nofault;
        sel_act_r[3] == `FN_NO_FAULT && fault_detected |=> !multi_line_4_out;
    endproperty
    a_nofault: assert property (p_nofault) else $error("no-fault output high in fault"); // R10

    property p_gp;
        sel_act_r[2] == `FN_FREE_OUT |=> multi_line_3_out == $past(gp_out_r[2]);
    endproperty
    a_gp: assert property (p_gp) else $error("general output mismatch"); // R9

    property p_enable_local;
        state_r == st_ready_to_switch_on && !local_mode && !fb_enable_op
            && !mode_start && !fault_detected && !power_up |=> state_r == st_ready_to_switch_on;
    endproperty
    a_enable_local: assert property (p_enable_local) else $error("enable outside local mode"); // R3

    property p_seq;
        state_r == st_start && elec_init_done && !power_up |=> state_r == st_not_ready;
    endproperty
    a_seq: assert property (p_seq) else $error("start state did not advance"); // R14

    property p_pos_lim;
        sel_act_r[0] == `FN_POS_LIM && sync2_r[0] |=> positive_travel_switch;
    endproperty
    a_pos_lim: assert property (p_pos_lim) else $error("limit switch not seen"); // R7

    c_wr_ok: cover property (wr_ok);
    c_reject: cover property (wr && sel_hit && !wr_ok);
    c_power_up: cover property (power_up ##1 sel_act_r[2] != `LINE3_FACTORY);
    c_op_en: cover property (state_r == st_operation_enabled);
endmodule

// File: tb/field_wiring.sv
`timescale 1ns/1ps
module field_wiring (
    input wire logic [3:0] sw_level,
    input wire logic [3:0] drv_level,
    input wire logic [3:0] drv_oe_n,
    output logic [3:0] pin_level
);
    // a driven line shows the device level, an undriven one the switch contact
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = drv_oe_n[i] ? sw_level[i] : drv_level[i];
        end
    end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "lio_map.svh"
module tb_top;
    import lio_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic par_req = 1'b0;
    logic par_we = 1'b0;
    logic [15:0] par_addr = 16'h0000;
    logic [15:0] par_wdata = 16'h0000;
    logic par_ack;
    logic par_err;
    logic [15:0] par_rdata;
    logic power_up = 1'b0;
    logic elec_init_done = 1'b0;
    logic param_init_done = 1'b0;
    logic supply_ok = 1'b0;
    logic local_mode = 1'b0;
    logic fault_detected = 1'b0;
    logic fb_enable_op = 1'b0;
    logic fb_disable_op = 1'b0;
    logic fb_fault_reset = 1'b0;
    logic mode_start = 1'b0;
    logic [3:0] sw_level = 4'h0;
    logic [3:0] pin_level;
    logic [3:0] line_out;
    logic [3:0] line_oe_n;
    op_state_e op_state;
    logic power_stage_on;
    logic [6:0] roles;
    int err_count = 0;
    int checked = 0;
    logic err_seen;
    logic [15:0] rd;

    always #20 mclk = ~mclk;

    multi_io_function_select dut (.mclk(mclk), .srst(srst), .par_req(par_req),
        .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack),
        .par_err(par_err), .par_rdata(par_rdata), .power_up(power_up),
        .elec_init_done(elec_init_done), .param_init_done(param_init_done),
        .supply_ok(supply_ok), .local_mode(local_mode), .fault_detected(fault_detected),
        .fb_enable_op(fb_enable_op), .fb_disable_op(fb_disable_op),
        .fb_fault_reset(fb_fault_reset), .mode_start(mode_start),
        .multi_line_1_in(pin_level[0]), .multi_line_1_out(line_out[0]),
        .multi_line_1_oe_n(line_oe_n[0]), .multi_line_2_in(pin_level[1]),
        .multi_line_2_out(line_out[1]), .multi_line_2_oe_n(line_oe_n[1]),
        .multi_line_3_in(pin_level[2]), .multi_line_3_out(line_out[2]),
        .multi_line_3_oe_n(line_oe_n[2]), .multi_line_4_in(pin_level[3]),
        .multi_line_4_out(line_out[3]), .multi_line_4_oe_n(line_oe_n[3]),
        .op_state(op_state), .power_stage_on(power_stage_on), .halt_request(roles[6]),
        .jog_pos_req(roles[5]), .jog_neg_req(roles[4]), .jog_fast_sel(roles[3]),
        .home_ref_switch(roles[2]), .positive_travel_switch(roles[1]),
        .negative_travel_switch(roles[0]));

    field_wiring wiring (.sw_level(sw_level), .drv_level(line_out), .drv_oe_n(line_oe_n),
        .pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic par_access(input logic we, input logic [15:0] addr, input logic [15:0] wd);
        cyc(1);
        par_req = 1'b1;
        par_we = we;
        par_addr = addr;
        par_wdata = wd;
        cyc(1);
        par_req = 1'b0;
        check({15'h0000, par_ack}, 16'h0001, "ack");
        err_seen = par_err;
        rd = par_rdata;
    endtask

    task automatic sel_write(input int idx, input logic [15:0] code, input logic exp_err);
        par_access(1'b1, 16'h0722 + 16'(2 * idx), code);
        check({15'h0000, err_seen}, {15'h0000, exp_err}, "write refusal");
    endtask

    task automatic sel_read(input int idx, input logic [15:0] exp);
        par_access(1'b0, 16'h0722 + 16'(2 * idx), 16'h0000);
        check(rd, exp, "selector readback");
    endtask

    task automatic wait_state(input op_state_e s);
        int n;
        n = 0;
        while (op_state !== s && n < 20) begin
            cyc(1);
            n++;
        end
        check({13'h0000, op_state}, {13'h0000, s}, "state");
    endtask

    task automatic restart();
        cyc(1);
        power_up = 1'b1;
        cyc(1);
        power_up = 1'b0;
        wait_state(st_ready_to_switch_on);
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] fac [4];
        fac = '{`LINE1_FACTORY, `LINE2_FACTORY, `LINE3_FACTORY, `LINE4_FACTORY};
        for (int i = 0; i < 4; i++) sel_read(i, fac[i]);
        check({12'h000, line_oe_n}, 16'h000f, "lines released");
        check({13'h0000, op_state}, {13'h0000, st_start}, "start");
    endtask

    task automatic t_factory_roles();
        sw_level = 4'hf;
        cyc(4);
        check({9'h000, roles}, 16'h0007, "factory roles");
        par_access(1'b0, `IN_LEVELS_ADDR, 16'h0000);
        check(rd, 16'h000f, "input levels");
        sw_level = 4'h0;
        cyc(4);
        check({9'h000, roles}, 16'h0000, "roles idle");
        par_access(1'b0, `IN_LEVELS_ADDR, 16'h0000);
        check(rd, 16'h0000, "input levels low");
    endtask

    task automatic t_refuse();
        sel_write(1, `FN_POS_LIM, 1'b1);
        sel_read(1, `FN_NEG_LIM);
        sel_write(3, `FN_POS_LIM, 1'b1);
        sel_write(0, `FN_NEG_LIM, 1'b1);
        sel_read(0, `FN_POS_LIM);
        sel_write(2, 16'h0005, 1'b1);
        sel_read(2, `FN_FREE_IN);
        par_access(1'b0, 16'h0700, 16'h0000);
        check({15'h0000, err_seen}, 16'h0001, "unmapped err");
        check(rd, 16'h0000, "unmapped data");
    endtask

    task automatic t_states();
        elec_init_done = 1'b1;
        param_init_done = 1'b1;
        supply_ok = 1'b1;
        wait_state(st_ready_to_switch_on);
        fb_enable_op = 1'b1;
        cyc(1);
        fb_enable_op = 1'b0;
        wait_state(st_operation_enabled);
        check({15'h0000, power_stage_on}, 16'h0001, "stage on");
        sel_write(2, `FN_HALT, 1'b1);
        sel_read(2, `FN_FREE_IN);
        fb_disable_op = 1'b1;
        cyc(1);
        fb_disable_op = 1'b0;
        wait_state(st_ready_to_switch_on);
        check({15'h0000, power_stage_on}, 16'h0000, "stage off");
    endtask

    task automatic t_inputs();
        logic [15:0] codes [5];
        logic [6:0] bits [5];
        codes = '{`FN_HALT, `FN_JOG_POS, `FN_JOG_NEG, `FN_JOG_FAST, `FN_HOME_REF};
        bits = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04};
        for (int i = 0; i < 5; i++) begin
            sel_write(2, codes[i], 1'b0);
            sel_read(2, codes[i]);
            sw_level = 4'h4;
            cyc(4);
            check({9'h000, roles & bits[i]}, 16'h0000, "not yet active");
            restart();
            check({9'h000, roles}, {9'h000, bits[i]}, "input role");
            sw_level = 4'h0;
            cyc(4);
            check({9'h000, roles}, 16'h0000, "role released");
        end
    endtask

    task automatic t_outputs();
        sel_write(2, `FN_FREE_OUT, 1'b0);
        sel_write(3, `FN_NO_FAULT, 1'b0);
        par_access(1'b1, `OUT_LEVELS_ADDR, 16'h0004);
        par_access(1'b0, `OUT_LEVELS_ADDR, 16'h0000);
        check(rd, 16'h0004, "out levels readback");
        restart();
        check({12'h000, line_oe_n}, 16'h0003, "drive enables");
        check({12'h000, pin_level & 4'hc}, 16'h000c, "out levels");
        par_access(1'b1, `OUT_LEVELS_ADDR, 16'h0000);
        cyc(2);
        check({15'h0000, line_out[2]}, 16'h0000, "general out low");
        fault_detected = 1'b1;
        cyc(3);
        check({15'h0000, line_out[3]}, 16'h0000, "fault shown");
        wait_state(st_fault);
        fault_detected = 1'b0;
        fb_fault_reset = 1'b1;
        cyc(1);
        fb_fault_reset = 1'b0;
        wait_state(st_ready_to_switch_on);
        cyc(2);
        check({15'h0000, line_out[3]}, 16'h0001, "no fault shown");
        sel_write(2, `FN_READY, 1'b0);
        restart();
        mode_start = 1'b1;
        cyc(1);
        mode_start = 1'b0;
        wait_state(st_operation_enabled);
        cyc(2);
        check({15'h0000, line_out[2]}, 16'h0001, "ready shown");
        fb_disable_op = 1'b1;
        cyc(1);
        fb_disable_op = 1'b0;
        wait_state(st_ready_to_switch_on);
    endtask

    task automatic t_local();
        sel_write(2, `FN_ENABLE, 1'b0);
        sel_write(3, `FN_FAULT_RST, 1'b0);
        restart();
        sw_level = 4'h4;
        cyc(6);
        check({13'h0000, op_state}, {13'h0000, st_ready_to_switch_on}, "remote enable");
        local_mode = 1'b1;
        wait_state(st_operation_enabled);
        sw_level = 4'h0;
        fb_disable_op = 1'b1;
        cyc(1);
        fb_disable_op = 1'b0;
        wait_state(st_ready_to_switch_on);
        local_mode = 1'b0;
        fault_detected = 1'b1;
        wait_state(st_fault);
        fault_detected = 1'b0;
        sw_level = 4'h8;
        cyc(6);
        check({13'h0000, op_state}, {13'h0000, st_fault}, "remote reset");
        local_mode = 1'b1;
        wait_state(st_ready_to_switch_on);
        sw_level = 4'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        cyc(5);
        srst = 1'b0;
        t_reset();
        t_factory_roles();
        t_refuse();
        t_states();
        t_inputs();
        t_outputs();
        t_local();
        give_verdict();
    end
endmodule
